// ### logic/cpgio_ctrl.sv
// control pins, interrupts and gpio for one processor subsystem
//
// Chosen here: the placing of the registers and the APB interface to the registers.
module cpgio_ctrl #(
  parameter int N_IRQ = 4,
  parameter int N_GPIO = 4
) (
  // clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // asynchronous pins
  input wire logic [N_IRQ-1:0] ext_user_irq,
  input wire logic nmi_in_n,
  input wire logic reset_in_n,
  input wire logic port_mode_select,
  input wire logic output_disable_n,
  // core side
  input wire logic timer_in,
  input wire logic io_access,
  input wire logic irq_ack,
  output logic core_halt,
  output logic fetch_restart,
  output logic [15:0] fetch_addr,
  output logic irq_req,
  output logic [15:0] irq_vector,
  output logic branch_condition_input,
  output logic rom_enable,
  output logic host_port_mode,
  // flag pin
  output logic flag_output,
  output logic flag_output_oe,
  // gpio pins
  input wire logic [N_GPIO-1:0] gpio_in,
  output logic [N_GPIO-1:0] gpio_out,
  output logic [N_GPIO-1:0] gpio_oe
);
  typedef struct packed {
    logic [N_IRQ-1:0] irq_flag_reg;
    logic [N_IRQ-1:0] irq_mask_reg;
    logic global_irq_mode_bit;
    logic flag_bit;
    logic timer_output_select;
    logic host_mux_select;
    logic processor_mode_bit;
    logic [N_GPIO-1:0] gpio_val;
    logic [N_GPIO-1:0] pin_direction_field;
    logic [N_IRQ-1:0] irq_prev;
    logic nmi_prev;
    logic nmi_pend;
    logic rst_prev;
    logic strap_taken;
    logic rom_enable;
    logic fetch_restart;
    logic irq_req;
    logic [15:0] irq_vector;
    logic [31:0] prdata;
    logic pslverr;
    logic [N_GPIO-1:0] gpio_in_q;
  } cpgio_ctrl_state_t;

  cpgio_ctrl_state_t st;
  cpgio_ctrl_state_t next_st;
  logic [N_IRQ-1:0] irq_s;
  logic nmi_s_n;
  logic rst_s_n;
  logic mode_s;
  logic [N_GPIO-1:0] gpio_s;
  logic [N_IRQ-1:0] irq_gated;
  logic irq_any;
  logic [$clog2(N_IRQ)-1:0] irq_idx;
  logic wr_en;
  logic rd_en;
  logic [15:0] ack_off;
  logic [$clog2(N_IRQ)-1:0] ack_idx;

  // pin synchronisers
  // sync stages clear to zero, so the reset pin reads as held just after arst
  // two stage sync
  cpgio_sync #(.WIDTH(N_IRQ + 3)) u_sync_ctl (
    .clk(clk),
    .arst_n(arst_n),
    .async_in({ext_user_irq, nmi_in_n, reset_in_n, port_mode_select}),
    .sync_out({irq_s, nmi_s_n, rst_s_n, mode_s})
  );
  cpgio_sync #(.WIDTH(N_GPIO)) u_sync_gpio (
    .clk(clk),
    .arst_n(arst_n),
    .async_in(gpio_in),
    .sync_out(gpio_s)
  );

  assign irq_gated = st.global_irq_mode_bit ? (st.irq_flag_reg & st.irq_mask_reg) : '0;

  cpgio_irq_pri #(.N(N_IRQ)) u_pri (
    .pending(irq_gated),
    .any(irq_any),
    .index(irq_idx)
  );

  // index of the user interrupt being acknowledged
  assign ack_off = st.irq_vector - cpgio_pkg::USER_IRQ_VECTOR_BASE;
  assign ack_idx = ack_off[$clog2(N_IRQ)-1:0];

  // apb decode, zero wait states
  assign wr_en = psel && penable && pwrite;
  assign rd_en = psel && !penable && !pwrite;

  // read mux for the setup cycle
  function automatic logic [31:0] read_word(input logic [7:0] a, input cpgio_ctrl_state_t s);
    logic [31:0] w;
    w = '0;
    unique case (a)
      cpgio_pkg::ADDR_IRQ_FLAG: w[N_IRQ-1:0] = s.irq_flag_reg;
      cpgio_pkg::ADDR_IRQ_MASK: w[N_IRQ-1:0] = s.irq_mask_reg;
      cpgio_pkg::ADDR_CTRL: begin
        w[cpgio_pkg::CTRL_GLOBAL_IRQ_BIT] = s.global_irq_mode_bit;
        w[cpgio_pkg::CTRL_FLAG_OUT_BIT] = s.flag_bit;
        w[cpgio_pkg::CTRL_TIMER_OUT_BIT] = s.timer_output_select;
        w[cpgio_pkg::CTRL_HOST_MUX_BIT] = s.host_mux_select;
        w[cpgio_pkg::CTRL_PROC_MODE_BIT] = s.processor_mode_bit;
      end
      cpgio_pkg::ADDR_GPIO: begin
        w[cpgio_pkg::GPIO_VAL_LSB +: N_GPIO] = s.gpio_in_q;
        w[cpgio_pkg::GPIO_DIR_LSB +: N_GPIO] = s.pin_direction_field;
      end
      cpgio_pkg::ADDR_STATUS: begin
        w[0] = s.rom_enable;
        w[1] = s.nmi_pend;
      end
      default: w = '0;
    endcase
    return w;
  endfunction

  function automatic logic addr_ok(input logic [7:0] a);
    return a == cpgio_pkg::ADDR_IRQ_FLAG || a == cpgio_pkg::ADDR_IRQ_MASK ||
           a == cpgio_pkg::ADDR_CTRL || a == cpgio_pkg::ADDR_GPIO ||
           a == cpgio_pkg::ADDR_STATUS;
  endfunction

  // next state
  always_comb begin
    next_st = st;
    next_st.irq_prev = irq_s;
    next_st.nmi_prev = nmi_s_n;
    next_st.rst_prev = rst_s_n;
    next_st.fetch_restart = 1'b0;
    next_st.gpio_in_q = gpio_s;
    // capture read data in the setup cycle, writes read back zero
    if (psel && !penable) begin
      next_st.prdata = rd_en ? read_word(paddr, st) : 32'h0000_0000;
      next_st.pslverr = !addr_ok(paddr);
    end
    if (!rst_s_n) begin
      next_st.irq_flag_reg = '0;
      next_st.irq_mask_reg = '0;
      next_st.global_irq_mode_bit = cpgio_pkg::CTRL_RESET[cpgio_pkg::CTRL_GLOBAL_IRQ_BIT];
      next_st.flag_bit = 1'b0;
      next_st.timer_output_select = 1'b0;
      next_st.host_mux_select = 1'b0;
      next_st.gpio_val = '0;
      next_st.pin_direction_field = cpgio_pkg::GPIO_DIR_RESET;
      next_st.nmi_pend = 1'b0;
      next_st.irq_req = 1'b0;
      next_st.strap_taken = 1'b0;
    end else begin
      // software writes; flags clear on write one
      if (wr_en) begin
        unique case (paddr)
          cpgio_pkg::ADDR_IRQ_FLAG: next_st.irq_flag_reg = st.irq_flag_reg & ~pwdata[N_IRQ-1:0];
          cpgio_pkg::ADDR_IRQ_MASK: next_st.irq_mask_reg = pwdata[N_IRQ-1:0];
          cpgio_pkg::ADDR_CTRL: begin
            next_st.global_irq_mode_bit = pwdata[cpgio_pkg::CTRL_GLOBAL_IRQ_BIT];
            next_st.flag_bit = pwdata[cpgio_pkg::CTRL_FLAG_OUT_BIT];
            next_st.timer_output_select = pwdata[cpgio_pkg::CTRL_TIMER_OUT_BIT];
            next_st.host_mux_select = pwdata[cpgio_pkg::CTRL_HOST_MUX_BIT];
            next_st.processor_mode_bit = pwdata[cpgio_pkg::CTRL_PROC_MODE_BIT];
          end
          cpgio_pkg::ADDR_GPIO: begin
            next_st.gpio_val = pwdata[cpgio_pkg::GPIO_VAL_LSB +: N_GPIO];
            next_st.pin_direction_field = pwdata[cpgio_pkg::GPIO_DIR_LSB +: N_GPIO];
          end
          default: next_st.gpio_val = st.gpio_val;
        endcase
      end
      // rising edge sets flag, set wins
      next_st.irq_flag_reg = next_st.irq_flag_reg | (irq_s & ~st.irq_prev);
      if (!nmi_s_n && st.nmi_prev) begin
        next_st.nmi_pend = 1'b1;
      end
      // vector request, nmi first then priority
      if (irq_ack && st.irq_req) begin
        next_st.irq_req = 1'b0;
        if (st.irq_vector == cpgio_pkg::NMI_VECTOR) begin
          next_st.nmi_pend = 1'b0;
        end else begin
          // served flag drops unless a new edge sets it again
          next_st.irq_flag_reg[ack_idx] = irq_s[ack_idx] & ~st.irq_prev[ack_idx];
        end
      end else if (!st.irq_req) begin
        if (st.nmi_pend) begin
          next_st.irq_req = 1'b1;
          next_st.irq_vector = cpgio_pkg::NMI_VECTOR;
        end else if (irq_any) begin
          next_st.irq_req = 1'b1;
          next_st.irq_vector = cpgio_pkg::USER_IRQ_VECTOR_BASE + 16'(irq_idx);
        end
      end
      // strap mode bit, rom enable, at release
      if (!st.strap_taken) begin
        next_st.strap_taken = 1'b1;
        next_st.processor_mode_bit = mode_s;
        next_st.rom_enable = mode_s ? gpio_s[0] : 1'b0;
      end
      if (!st.rst_prev) begin
        next_st.fetch_restart = 1'b1;
      end
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  // apb answers
  assign pready = 1'b1;
  assign prdata = st.prdata;
  assign pslverr = st.pslverr & psel & penable;

  // core outputs
  // halt and restart vector
  assign core_halt = !st.rst_prev;
  assign fetch_restart = st.fetch_restart;
  assign fetch_addr = cpgio_pkg::RESTART_VECTOR;
  assign irq_req = st.irq_req;
  assign irq_vector = st.irq_vector;
  assign host_port_mode = !mode_s;
  assign rom_enable = st.rom_enable;
  assign branch_condition_input = st.pin_direction_field[2] ? 1'b0 : st.gpio_in_q[2];

  assign flag_output = st.flag_bit;
  assign flag_output_oe = output_disable_n;

  // gpio pin drive with pin 3 alternates
  always_comb begin
    gpio_out = st.gpio_val;
    gpio_oe = output_disable_n ? st.pin_direction_field : '0;
    // pin 0 is input in memory mode
    if (mode_s) begin
      gpio_oe[0] = 1'b0;
    end
    if (mode_s) begin
      gpio_out[3] = !io_access;
      gpio_oe[3] = output_disable_n;
    end else if (!st.host_mux_select && st.timer_output_select) begin
      gpio_out[3] = timer_in;
      gpio_oe[3] = output_disable_n;
    end
  end
endmodule

// ### common/cpgio_pkg.sv
// shared constants for the control pin and gpio block
package cpgio_pkg;
  // apb register byte addresses
  localparam logic [7:0] ADDR_IRQ_FLAG = 8'h00;
  localparam logic [7:0] ADDR_IRQ_MASK = 8'h04;
  localparam logic [7:0] ADDR_CTRL = 8'h08;
  localparam logic [7:0] ADDR_GPIO = 8'h0C;
  localparam logic [7:0] ADDR_STATUS = 8'h10;
  // control register field positions
  localparam int CTRL_GLOBAL_IRQ_BIT = 0;
  localparam int CTRL_FLAG_OUT_BIT = 1;
  localparam int CTRL_TIMER_OUT_BIT = 2;
  localparam int CTRL_HOST_MUX_BIT = 3;
  localparam int CTRL_PROC_MODE_BIT = 4;
  // gpio register layout: values in 3:0, directions in 11:8
  localparam int GPIO_VAL_LSB = 0;
  localparam int GPIO_DIR_LSB = 8;
  // values after reset, vectors and sync depth
  localparam logic [31:0] CTRL_RESET = 32'h0000_0001;
  localparam logic [3:0] GPIO_DIR_RESET = 4'h0;
  localparam logic [15:0] RESTART_VECTOR = 16'hFF80;
  localparam logic [15:0] NMI_VECTOR = 16'h00C0;
  localparam logic [15:0] USER_IRQ_VECTOR_BASE = 16'h00C4;
  localparam int SYNC_STAGES = 2;
endpackage

// ### logic/cpgio_sync.sv
// two stage level synchroniser bank
module cpgio_sync #(
  parameter int WIDTH = 1
) (
  // clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // data
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);
  typedef struct packed {
    logic [WIDTH-1:0] first;
    logic [WIDTH-1:0] second;
  } cpgio_sync_state_t;
  cpgio_sync_state_t st;
  cpgio_sync_state_t next_st;

  // shift chain, first stage read only by second
  always_comb begin
    next_st = st;
    next_st.first = async_in;
    next_st.second = st.first;
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign sync_out = st.second;
endmodule

// ### logic/cpgio_irq_pri.sv
// fixed priority pick among pending user interrupts
module cpgio_irq_pri #(
  parameter int N = 4
) (
  // request vector
  input wire logic [N-1:0] pending,
  // result
  output logic any,
  output logic [$clog2(N)-1:0] index
);
  // lowest index wins
  always_comb begin
    any = 1'b0;
    index = '0;
    for (int i = N - 1; i >= 0; i--) begin
      if (pending[i]) begin
        any = 1'b1;
        index = i[$clog2(N)-1:0];
      end
    end
  end
endmodule

// ### dv/cpgio_ctrl_chk.sv
// port assertions for the control pin and gpio block
module cpgio_ctrl_chk #(
  parameter int N_GPIO = 4
) (
  // clock and reset
  input logic clk,
  input logic arst_n,
  // apb
  input logic psel,
  input logic penable,
  input logic [7:0] paddr,
  input logic pready,
  input logic pslverr,
  // pins
  input logic port_mode_select,
  input logic reset_in_n,
  input logic output_disable_n,
  input logic io_access,
  // core side
  input logic core_halt,
  input logic fetch_restart,
  input logic [15:0] fetch_addr,
  input logic irq_req,
  input logic [15:0] irq_vector,
  input logic branch_condition_input,
  input logic host_port_mode,
  input logic flag_output_oe,
  input logic [N_GPIO-1:0] gpio_out,
  input logic [N_GPIO-1:0] gpio_oe
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking @(posedge clk); endclocking
  default disable iff (!arst_n);
  // bus answer and refusal
  AST_PREADY:
    assert property (psel |-> pready) else $error("pready low");
  AST_UNMAPPED:
    assert property (psel && penable && paddr > 8'h10 |-> pslverr) else $error("no pslverr");
  AST_ERR_PHASE:
    assert property (pslverr |-> psel && penable) else $error("stray pslverr");
  // output disable floats pins
  AST_FLAG_FLOAT:
    assert property (flag_output_oe == output_disable_n) else $error("flag oe wrong");
  AST_GPIO_FLOAT:
    assert property (!output_disable_n |-> gpio_oe == '0) else $error("gpio oe wrong");
  // synced mode and reset pins
  AST_HOST_MODE:
    assert property ($stable(port_mode_select) [*5] |-> host_port_mode == !port_mode_select)
      else $error("port mode wrong");
  AST_HALT:
    assert property (!reset_in_n [*5] |-> core_halt) else $error("no halt");
  AST_RESTART:
    assert property (fetch_restart |-> fetch_addr == cpgio_pkg::RESTART_VECTOR ##1 !fetch_restart)
      else $error("restart wrong");
  // interrupt vectors and pin functions
  AST_VECTOR:
    assert property (irq_req |-> irq_vector == cpgio_pkg::NMI_VECTOR
      || irq_vector inside {[16'h00C4:16'h00C7]}) else $error("bad vector");
  AST_BRANCH:
    assert property (gpio_oe[2] |-> !branch_condition_input) else $error("branch flag set");
  AST_STROBE:
    assert property ((!host_port_mode && !core_halt && $stable(io_access)) [*3]
      |-> gpio_out[3] == !io_access) else $error("strobe wrong");
  // main scenarios reached
  COV_IRQ: cover property (irq_req);
  COV_RESTART: cover property (fetch_restart);
  COV_ERR: cover property (pslverr);
  COV_MEM: cover property (!host_port_mode && io_access);
endmodule

bind cpgio_ctrl cpgio_ctrl_chk #(.N_GPIO(N_GPIO)) cpgio_ctrl_chk_i (.clk, .arst_n, .psel,
  .penable, .paddr, .pready, .pslverr, .port_mode_select, .reset_in_n, .output_disable_n,
  .io_access, .core_halt, .fetch_restart, .fetch_addr, .irq_req, .irq_vector,
  .branch_condition_input, .host_port_mode, .flag_output_oe, .gpio_out, .gpio_oe);

// ### dv/cpgio_board.sv
// board model driving the asynchronous pins of one subsystem
module cpgio_board (
  // clock and bus activity
  input logic clk,
  input logic bus_busy,
  // gpio pins
  input logic [3:0] gpio_out,
  input logic [3:0] gpio_oe,
  output logic [3:0] gpio_in,
  // asynchronous pins
  output logic [3:0] ext_user_irq = 4'h0,
  output logic nmi_in_n = 1'b1,
  output logic reset_in_n = 1'b1,
  output logic port_mode_select = 1'b0,
  output logic output_disable_n = 1'b1
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [3:0] drive = 4'h0;
  // pin level, the block wins where it drives
  assign gpio_in = (gpio_oe & gpio_out) | (~gpio_oe & drive);
  task automatic set_mode(logic m);
    while (bus_busy) @(posedge clk);
    port_mode_select <= m;
  endtask
endmodule

// ### dv/tb_cpgio_ctrl.sv
// self-checking bench for the control pin and gpio block
module tb_cpgio_ctrl;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk = 0, arst_n = 0, psel = 0, penable = 0, pwrite = 0;
  logic timer_in = 0, io_access = 0, irq_ack = 0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata;
  logic pready, pslverr, nmi_in_n, reset_in_n, port_mode_select, output_disable_n;
  logic core_halt, fetch_restart, irq_req, branch_condition_input;
  logic rom_enable, host_port_mode, flag_output, flag_output_oe;
  logic [15:0] fetch_addr, irq_vector;
  logic [3:0] ext_user_irq, gpio_in, gpio_out, gpio_oe, v;
  logic [64:0] q[$];
  int n_fail = 0;
  int checks = 0;
  // block and board
  cpgio_ctrl cpgio_ctrl_i (.clk, .arst_n, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .ext_user_irq, .nmi_in_n, .reset_in_n, .port_mode_select,
    .output_disable_n, .timer_in, .io_access, .irq_ack, .core_halt, .fetch_restart,
    .fetch_addr, .irq_req, .irq_vector, .branch_condition_input, .rom_enable,
    .host_port_mode, .flag_output, .flag_output_oe, .gpio_in, .gpio_out, .gpio_oe);
  cpgio_board cpgio_board_i (.clk, .bus_busy(psel), .gpio_out, .gpio_oe, .gpio_in,
    .ext_user_irq, .nmi_in_n, .reset_in_n, .port_mode_select, .output_disable_n);
  // clock
  initial begin
    forever #12.5 clk = ~clk;
  end
  task automatic chk(logic [32:0] seen, logic [32:0] exp);
    checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("unexpected at %0t: %h vs %h", $time, seen, exp);
    end
  endtask
  task automatic test_done();
    if (n_fail == 0 && checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task automatic tick(int n);
    repeat (n) @(posedge clk);
  endtask
  // one apb transfer, then an idle cycle
  task automatic apb(logic wr, logic [7:0] a, logic [31:0] d);
    psel <= 1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk) penable <= 1;
    do @(posedge clk); while (pready !== 1'b1);
    psel <= 0;
    penable <= 0;
    @(posedge clk);
  endtask
  task automatic rd(logic [7:0] a, logic [31:0] m, logic [31:0] e, logic err = 0);
    q.push_back({m, err, e});
    apb(0, a, 32'h0);
  endtask
  // wait for irq request or restart pulse
  task automatic till(logic s);
    for (int i = 0; i < 40 && (s ? fetch_restart : irq_req) !== 1'b1; i++) @(posedge clk);
    chk(s ? fetch_restart : irq_req, 1);
  endtask
  // compare each read answer with the oldest note
  always @(posedge clk) begin
    logic [64:0] e;
    if (psel && penable && !pwrite && q.size() > 0) begin
      e = q.pop_front();
      chk({pslverr, prdata & e[64:33]}, e[32:0]);
    end
  end
  // main sequence
  initial begin
    void'($urandom(18));
    tick(16);
    arst_n <= 1;
    tick(1);
    rd(cpgio_pkg::ADDR_IRQ_MASK, '1, 0);
    rd(cpgio_pkg::ADDR_GPIO, 32'hF00, 0);
    rd(8'h14, '1, 0, 1);
    v = 4'($urandom);
    apb(1, cpgio_pkg::ADDR_GPIO, {20'h0, 4'hF, 4'h0, v});
    chk(gpio_out, v);
    chk(gpio_oe, 4'hF);
    tick(3);
    rd(cpgio_pkg::ADDR_GPIO, 32'hF0F, {20'h0, 4'hF, 4'h0, v});
    v = 4'($urandom) | 4'h4;
    cpgio_board_i.drive <= v;
    apb(1, cpgio_pkg::ADDR_GPIO, 32'h0);
    tick(3);
    rd(cpgio_pkg::ADDR_GPIO, 32'hF0F, {28'h0, v});
    chk({gpio_oe, branch_condition_input}, 1);
    apb(1, cpgio_pkg::ADDR_GPIO, 32'h400);
    tick(3);
    chk(branch_condition_input, 0);
    apb(1, cpgio_pkg::ADDR_CTRL, 32'h5);
    apb(1, cpgio_pkg::ADDR_GPIO, 32'hF00);
    for (int t = 0; t < 2; t++) begin
      timer_in <= t[0];
      tick(3);
      chk(gpio_out[3], t[0]);
    end
    apb(1, cpgio_pkg::ADDR_CTRL, 32'h7);
    chk(flag_output, 1);
    cpgio_board_i.output_disable_n <= 0;
    tick(2);
    chk({flag_output_oe, gpio_oe}, 0);
    cpgio_board_i.output_disable_n <= 1;
    apb(1, cpgio_pkg::ADDR_IRQ_MASK, 32'hF);
    cpgio_board_i.ext_user_irq <= 4'h6;
    till(0);
    chk(irq_vector, cpgio_pkg::USER_IRQ_VECTOR_BASE + 16'h1);
    rd(cpgio_pkg::ADDR_IRQ_FLAG, 32'hF, 32'h6);
    apb(1, cpgio_pkg::ADDR_IRQ_FLAG, 32'hF);
    rd(cpgio_pkg::ADDR_IRQ_FLAG, 32'hF, 0);
    irq_ack <= 1;
    tick(1);
    irq_ack <= 0;
    apb(1, cpgio_pkg::ADDR_IRQ_MASK, 32'h0);
    cpgio_board_i.ext_user_irq <= 4'h1;
    tick(8);
    chk(irq_req, 0);
    rd(cpgio_pkg::ADDR_IRQ_FLAG, 32'hF, 32'h1);
    apb(1, cpgio_pkg::ADDR_IRQ_FLAG, 32'hF);
    apb(1, cpgio_pkg::ADDR_CTRL, 32'h0);
    cpgio_board_i.nmi_in_n <= 0;
    till(0);
    chk(irq_vector, cpgio_pkg::NMI_VECTOR);
    irq_ack <= 1;
    tick(1);
    irq_ack <= 0;
    cpgio_board_i.set_mode(1);
    cpgio_board_i.drive <= 4'h1;
    cpgio_board_i.reset_in_n <= 0;
    tick(6);
    chk(core_halt, 1);
    cpgio_board_i.reset_in_n <= 1;
    till(1);
    chk(fetch_addr, cpgio_pkg::RESTART_VECTOR);
    rd(cpgio_pkg::ADDR_CTRL, 32'h10, 32'h10);
    rd(cpgio_pkg::ADDR_STATUS, 32'h1, 32'h1);
    chk(host_port_mode, 0);
    chk(rom_enable, 1);
    repeat (20) begin
      io_access <= 1'($urandom);
      tick(4);
      chk({gpio_oe[3], gpio_out[3]}, {1'b1, !io_access});
    end
    test_done();
  end
  // hang guard, far past the sequence length
  initial begin
    tick(4000);
    n_fail++;
    test_done();
  end
endmodule
